// ==== serial_flash_cmds.sv ====
`timescale 1ns/1ps
module serial_flash_cmds
	import flash_pkg::*;
#(
	parameter int ADDR_W     = ARRAY_ADDR_W,
	parameter int PROG_CYC   = PROG_CYCLES,
	parameter int SECTOR_CYC = SECTOR_CYCLES,
	parameter int BLOCK_CYC  = BLOCK_CYCLES,
	parameter int CHIP_CYC   = CHIP_CYCLES,
	parameter int SLEEP_CYC  = SLEEP_CYCLES,
	parameter int WAKE_CYC   = WAKE_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       serial_in_i,
	input  wire logic [2:0] protect_level_bits_i,
	output logic            serial_out_o,
	output logic            serial_out_oe_n_o,
	output logic            write_busy_flag_o,
	output logic            write_enable_latch_o,
	output logic            deep_sleep_o,
	output logic            standby_o
);

	logic [7:0]            mem [2**ADDR_W];
	logic [7:0]            page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_r;

	link_t             sync1_r;
	link_t             sync2_r;
	link_t             prev_r;
	proto_t            state_r;
	op_t               cmd_r;
	op_t               op_in;
	op_t               eop_r;
	pwr_t              pwr_r;
	logic [2:0]        bit_cnt_r;
	logic [1:0]        byte_cnt_r;
	logic [7:0]        shift_r;
	logic [7:0]        in_byte;
	logic [7:0]        out_sh_r;
	logic [2:0]        out_bit_r;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] region_mask;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] ptr_r;
	logic [ADDR_W:0]   left_r;
	logic [31:0]       busy_cnt_r;
	logic [31:0]       pwr_cnt_r;
	logic              have_data_r;
	logic              dout_r;
	logic              drive_r;
	logic              wel_r;
	logic              busy_r;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              cs_rise;
	logic              byte_done;
	logic              accepting;
	logic              clean_end;
	logic              exec_prog;
	logic              exec_erase;
	logic              start_cycle;

	function automatic op_t decode_op(input logic [7:0] b);
		case (b)
			OPC_FAST_READ:            decode_op = OP_READ;
			OPC_PAGE_PROG:            decode_op = OP_PROG;
			OPC_SECTOR_WIPE:          decode_op = OP_SECT;
			OPC_BLOCK_A, OPC_BLOCK_B: decode_op = OP_BLK;
			OPC_CHIP_A, OPC_CHIP_B:   decode_op = OP_CHIP;
			OPC_SLEEP:                decode_op = OP_SLEEP;
			OPC_WAKE:                 decode_op = OP_WAKE;
			OPC_UNLOCK:               decode_op = OP_UNLOCK;
			default:                  decode_op = OP_NONE;
		endcase
	endfunction

	// the protected area is the top of the array, growing with the level
	function automatic logic is_protected(input logic [ADDR_W-1:0] a,
		input logic [2:0] lvl);
		int lo;
		lo = ADDR_W - 7 + int'(lvl);
		is_protected = (lvl != 3'd0);
		for (int i = 0; i < ADDR_W; i++) begin
			if (i >= lo && !a[i]) begin
				is_protected = 1'b0;
			end
		end
	endfunction

	// link pins cross into clk_i through two flops before any use
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_r <= LINK_IDLE;
			sync2_r <= LINK_IDLE;
			prev_r  <= LINK_IDLE;
		end else begin
			sync1_r <= '{cs_n: cs_n_i, sclk: sclk_i, din: serial_in_i};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign sclk_rise = sync2_r.sclk & ~prev_r.sclk & ~sync2_r.cs_n;
	assign sclk_fall = ~sync2_r.sclk & prev_r.sclk & ~sync2_r.cs_n;
	assign cs_rise   = sync2_r.cs_n & ~prev_r.cs_n;
	assign in_byte   = {shift_r[6:0], sync2_r.din};
	assign byte_done = sclk_rise && (bit_cnt_r == 3'd7);
	assign op_in     = decode_op(in_byte);
	assign accepting = (pwr_r == PWR_ACTIVE) && !busy_r;
	assign clean_end = cs_rise && (bit_cnt_r == 3'd0);

	always_comb begin
		case (cmd_r)
			OP_PROG: region_mask = ADDR_W'((1 << PAGE_W) - 1);
			// sector chosen by any address inside
			OP_SECT: region_mask = ADDR_W'((1 << SECTOR_W) - 1);
			// block chosen by any address inside
			OP_BLK:  region_mask = ADDR_W'((1 << BLOCK_W) - 1);
			default: region_mask = '1;
		endcase
	end

	assign base = addr_r & ~region_mask;

	// program needs a whole final data byte
	assign exec_prog = clean_end && (state_r == ST_PDATA) && have_data_r
		&& (cmd_r == OP_PROG);
	// erase needs select to rise on a byte boundary
	assign exec_erase = clean_end && (state_r == ST_TAIL)
		&& (cmd_r inside {OP_SECT, OP_BLK, OP_CHIP});

	// protection checked on the last byte of the target
	always_comb begin
		start_cycle = 1'b0;
		if (exec_prog || exec_erase) begin
			if (cmd_r == OP_CHIP) begin
				// chip erase only with no protection
				start_cycle = (protect_level_bits_i == 3'd0);
			end else begin
				start_cycle = !is_protected(base | region_mask,
					protect_level_bits_i);
			end
		end
	end

	// instruction framing and serial shifting
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r     <= ST_OPCODE;
			cmd_r       <= OP_NONE;
			bit_cnt_r   <= 3'd0;
			byte_cnt_r  <= 2'd0;
			shift_r     <= 8'h00;
			addr_r      <= '0;
			have_data_r <= 1'b0;
			mask_r      <= '0;
			out_sh_r    <= 8'h00;
			out_bit_r   <= 3'd0;
			dout_r      <= 1'b0;
			drive_r     <= 1'b0;
		end else if (sync2_r.cs_n) begin
			// deselect ends the instruction, output released
			state_r    <= ST_OPCODE;
			bit_cnt_r  <= 3'd0;
			byte_cnt_r <= 2'd0;
			drive_r    <= 1'b0;
		end else begin
			if (sclk_rise) begin
				// bits taken on the rising clock
				shift_r   <= in_byte;
				bit_cnt_r <= bit_cnt_r + 3'd1;
			end
			if (byte_done) begin
				case (state_r)
					ST_OPCODE: begin
						cmd_r   <= op_in;
						state_r <= ST_IGNORE;
						if (pwr_r == PWR_SLEEP) begin
							// only wake is heard while asleep
							if (op_in == OP_WAKE) begin
								state_r <= ST_TAIL;
							end
						end else if (accepting) begin
							case (op_in)
								OP_READ: begin
									state_r <= ST_ADDR;
								end
								OP_PROG, OP_SECT, OP_BLK: begin
									if (wel_r) begin
										state_r <= ST_ADDR;
									end
								end
								// chip erase ends at the opcode
								OP_CHIP: begin
									if (wel_r) begin
										state_r <= ST_TAIL;
									end
								end
								// sleep entry waits for the frame end
								OP_SLEEP: begin
									state_r <= ST_TAIL;
								end
								default: begin
									state_r <= ST_IGNORE;
								end
							endcase
						end
					end
					ST_ADDR: begin
						addr_r     <= {addr_r[ADDR_W-9:0], in_byte};
						byte_cnt_r <= byte_cnt_r + 2'd1;
						if (byte_cnt_r == 2'(ADDR_BYTES - 1)) begin
							if (cmd_r == OP_READ) begin
								state_r <= ST_DUMMY;
							end else if (cmd_r == OP_PROG) begin
								state_r     <= ST_PDATA;
								have_data_r <= 1'b0;
								mask_r      <= '0;
							end else begin
								state_r <= ST_TAIL;
							end
						end
					end
					ST_DUMMY: begin
						state_r   <= ST_READ;
						out_sh_r  <= mem[addr_r];
						out_bit_r <= 3'd0;
						addr_r    <= addr_r + 1'b1;
					end
					ST_PDATA: begin
						page_buf[addr_r[PAGE_W-1:0]] <= in_byte;
						mask_r[addr_r[PAGE_W-1:0]]   <= 1'b1;
						addr_r[PAGE_W-1:0] <= addr_r[PAGE_W-1:0] + 1'b1;
						have_data_r        <= 1'b1;
					end
					ST_TAIL: begin
						state_r <= ST_IGNORE;
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
			if (sclk_fall && state_r == ST_READ) begin
				// data leaves on the falling clock
				dout_r    <= out_sh_r[7];
				drive_r   <= 1'b1;
				out_sh_r  <= {out_sh_r[6:0], 1'b0};
				out_bit_r <= out_bit_r + 3'd1;
				if (out_bit_r == 3'd7) begin
					// address rolls over at the array top
					out_sh_r <= mem[addr_r];
					addr_r   <= addr_r + 1'b1;
				end
			end
		end
	end

	// write-enable latch
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wel_r <= 1'b0;
		end else if (byte_done && state_r == ST_OPCODE && accepting
			&& op_in == OP_UNLOCK) begin
			wel_r <= 1'b1;
		end else if (start_cycle) begin
			// latch cleared as the cycle starts
			wel_r <= 1'b0;
		end
	end

	// self-timed program/erase engine
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_r     <= 1'b0;
			eop_r      <= OP_NONE;
			busy_cnt_r <= 32'd0;
			ptr_r      <= '0;
			left_r     <= '0;
		end else if (start_cycle) begin
			// busy held for the whole timed cycle
			busy_r <= 1'b1;
			eop_r  <= cmd_r;
			ptr_r  <= base;
			left_r <= {1'b0, region_mask} + 1'b1;
			case (cmd_r)
				OP_PROG: busy_cnt_r <= 32'(PROG_CYC);
				OP_SECT: busy_cnt_r <= 32'(SECTOR_CYC);
				OP_BLK:  busy_cnt_r <= 32'(BLOCK_CYC);
				default: busy_cnt_r <= 32'(CHIP_CYC);
			endcase
		end else if (busy_r) begin
			if (left_r != '0) begin
				left_r <= left_r - 1'b1;
				ptr_r  <= ptr_r + 1'b1;
			end
			if (busy_cnt_r > 32'd1) begin
				busy_cnt_r <= busy_cnt_r - 32'd1;
			end else if (left_r == '0) begin
				busy_cnt_r <= 32'd0;
				busy_r     <= 1'b0;
			end
		end
	end

	// array writes, one byte per clock while the engine walks
	always_ff @(posedge clk_i) begin
		if (busy_r && left_r != '0) begin
			if (eop_r == OP_PROG) begin
				if (mask_r[ptr_r[PAGE_W-1:0]]) begin
					mem[ptr_r] <= mem[ptr_r] & page_buf[ptr_r[PAGE_W-1:0]];
				end
			end else begin
				mem[ptr_r] <= ERASED_BYTE;
			end
		end
	end

	// power modes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pwr_r     <= PWR_ACTIVE;
			pwr_cnt_r <= 32'd0;
		end else begin
			case (pwr_r)
				PWR_ACTIVE: begin
					// clean B9h frame starts the entry delay
					if (clean_end && state_r == ST_TAIL
						&& cmd_r == OP_SLEEP) begin
						pwr_r     <= PWR_ENTER;
						pwr_cnt_r <= 32'(SLEEP_CYC);
					end
				end
				PWR_ENTER: begin
					pwr_cnt_r <= pwr_cnt_r - 32'd1;
					if (pwr_cnt_r <= 32'd1) begin
						pwr_r <= PWR_SLEEP;
					end
				end
				PWR_SLEEP: begin
					// wake code then the release delay
					if (clean_end && state_r == ST_TAIL
						&& cmd_r == OP_WAKE) begin
						pwr_r     <= PWR_WAKE;
						pwr_cnt_r <= 32'(WAKE_CYC);
					end
				end
				PWR_WAKE: begin
					pwr_cnt_r <= pwr_cnt_r - 32'd1;
					if (pwr_cnt_r <= 32'd1) begin
						pwr_r <= PWR_ACTIVE;
					end
				end
				default: begin
					pwr_r <= PWR_ACTIVE;
				end
			endcase
		end
	end

	assign serial_out_o         = dout_r;
	assign serial_out_oe_n_o    = ~drive_r;
	assign write_busy_flag_o    = busy_r;
	assign write_enable_latch_o = wel_r;
	assign deep_sleep_o         = (pwr_r == PWR_SLEEP);
	// idle and deselected means standby, not deep sleep
	assign standby_o = sync2_r.cs_n && !busy_r && (pwr_r == PWR_ACTIVE);

endmodule

// ==== flash_pkg.sv ====
package flash_pkg;

	// serial link pins, sampled together
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} link_t;

	localparam link_t LINK_IDLE = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

	// array geometry
	localparam int ARRAY_ADDR_W = 18;
	localparam int ADDR_BYTES   = 3;
	localparam int PAGE_W       = 8;
	localparam int SECTOR_W     = 12;
	localparam int BLOCK_W      = 16;
	localparam int PAGE_BYTES   = 256;

	// instruction codes and the erased byte value
	localparam logic [7:0] OPC_FAST_READ   = 8'h0B;
	localparam logic [7:0] OPC_PAGE_PROG   = 8'h02;
	localparam logic [7:0] OPC_SECTOR_WIPE = 8'h20;
	localparam logic [7:0] OPC_BLOCK_A     = 8'hD8;
	localparam logic [7:0] OPC_BLOCK_B     = 8'h52;
	localparam logic [7:0] OPC_CHIP_A      = 8'hC7;
	localparam logic [7:0] OPC_CHIP_B      = 8'h60;
	localparam logic [7:0] OPC_SLEEP       = 8'hB9;
	localparam logic [7:0] OPC_WAKE        = 8'hAB;
	localparam logic [7:0] OPC_UNLOCK      = 8'h06;
	localparam logic [7:0] ERASED_BYTE     = 8'hFF;

	// self-timed durations and their cycle counts at the system clock
	localparam int CLK_PERIOD_NS         = 8;
	localparam int PROG_TIME_NS          = 100000;
	localparam int ERASE_CYCLE_TIME_NS   = 1000000;
	localparam int BLOCK_ERASE_TIME_NS   = 2000000;
	localparam int CHIP_WIPE_TIME_NS     = 5000000;
	localparam int SLEEP_ENTRY_DELAY_NS  = 3000;
	localparam int WAKE_DELAY_NS         = 3000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SECTOR_CYCLES = (ERASE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int BLOCK_CYCLES  = (BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CHIP_CYCLES   = (CHIP_WIPE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SLEEP_CYCLES  = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WAKE_CYCLES   = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_PDATA, ST_TAIL,
		ST_IGNORE} proto_t;
	typedef enum {OP_NONE, OP_READ, OP_PROG, OP_SECT, OP_BLK, OP_CHIP,
		OP_SLEEP, OP_WAKE, OP_UNLOCK} op_t;
	typedef enum {PWR_ACTIVE, PWR_ENTER, PWR_SLEEP, PWR_WAKE} pwr_t;

endpackage

// ==== flash_props.sv ====
`timescale 1ns/1ps
module flash_props
	import flash_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       cs_n_i,
	input wire logic       sclk_i,
	input wire logic       serial_in_i,
	input wire logic [2:0] protect_level_bits_i,
	input wire logic       serial_out_o,
	input wire logic       serial_out_oe_n_o,
	input wire logic       write_busy_flag_o,
	input wire logic       write_enable_latch_o,
	input wire logic       deep_sleep_o,
	input wire logic       standby_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// cycles since the host clock fell; saturates so it never wraps back
	logic [3:0] fall_age_r;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || $fell(sclk_i))
			fall_age_r <= 4'h0;
		else if (fall_age_r != 4'hf)
			fall_age_r <= fall_age_r + 4'h1;
	end
	sequence s_busy_start;
		$rose(write_busy_flag_o);
	endsequence
	property p_busy_gate;
		s_busy_start |-> cs_n_i && ($past(write_enable_latch_o)
			|| $past(write_enable_latch_o, 2));
	endproperty
	property p_wel_clear;
		s_busy_start |-> ##[0:2] !write_enable_latch_o;
	endproperty
	property p_standby;
		standby_o |-> !write_busy_flag_o && !deep_sleep_o;
	endproperty
	property p_sleep_quiet;
		deep_sleep_o |-> serial_out_oe_n_o && !write_busy_flag_o;
	endproperty
	property p_sleep_wel;
		$rose(write_enable_latch_o) |-> !$past(deep_sleep_o);
	endproperty
	property p_cs_release;
		cs_n_i [*6] |-> serial_out_oe_n_o;
	endproperty
	property p_shift_edge;
		$changed(serial_out_o) && !serial_out_oe_n_o && !cs_n_i
			&& !$past(cs_n_i, 5) |-> fall_age_r inside {[4'h1:4'h7]};
	endproperty
	property p_sleep_entry;
		$rose(deep_sleep_o) |-> cs_n_i && $past(cs_n_i, 8);
	endproperty
	a_busy_gate: assert property (p_busy_gate)
		else $error("busy started without latch or select");
	a_wel_clear: assert property (p_wel_clear)
		else $error("latch kept during cycle");
	a_standby: assert property (p_standby)
		else $error("standby while busy or asleep");
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity in deep sleep");
	a_sleep_wel: assert property (p_sleep_wel)
		else $error("latch set in deep sleep");
	a_cs_release: assert property (p_cs_release)
		else $error("output driven while deselected");
	a_shift_edge: assert property (p_shift_edge)
		else $error("output bit not moved by clock fall");
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("deep sleep entered while selected");
endmodule

// ==== spi_host.sv ====
`timescale 1ns/1ps
module spi_host
	import flash_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic dout_i,
	input  wire logic oe_n_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	logic last_r = 1'b0;
	initial begin
		cs_n_o = LINK_IDLE.cs_n;
		sclk_o = LINK_IDLE.sclk;
		din_o  = LINK_IDLE.din;
	end
	// select low for the whole frame
	task automatic start();
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (10) @(negedge clk_i);
	endtask
	// msb first, bit set up long before the rise
	task automatic xfer(input logic [7:0] tx, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			din_o = tx[i];
			repeat (10) @(negedge clk_i);
			// a released line reads as the inverse of the last bit
			rx[i] = oe_n_i ? ~last_r : dout_i;
			last_r = rx[i];
			sclk_o = 1'b1;
			repeat (10) @(negedge clk_i);
			sclk_o = 1'b0;
		end
	endtask
	// select rises after the last bit and stays high
	task automatic stop();
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		repeat (12) @(negedge clk_i);
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
	import flash_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] prot = 3'h0;
	logic       cs_n, sclk, din, dout, oe_n, busy, write_enable_latch, sleep, stby;
	logic [7:0] rx, d;
	logic [7:0] prog_q [int];
	logic [7:0] ops [4] = '{OPC_BLOCK_A, OPC_BLOCK_B, OPC_CHIP_A, OPC_CHIP_B};
	int         err_total = 0;
	int         n_compared = 0;
	always #4 clk = ~clk;
	// block and chip erase are only ever refused, so their times stay long
	serial_flash_cmds #(.ADDR_W(16), .PROG_CYC(20), .SECTOR_CYC(20),
		.SLEEP_CYC(20), .WAKE_CYC(20)) dut_u (
		.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
		.serial_in_i(din), .protect_level_bits_i(prot),
		.serial_out_o(dout), .serial_out_oe_n_o(oe_n),
		.write_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch),
		.deep_sleep_o(sleep), .standby_o(stby));
	spi_host host_u (.clk_i(clk), .dout_i(dout), .oe_n_i(oe_n),
		.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
	task automatic cmp_flag(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic cmp_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// only sector 0 is ever erased, so other places are unknown
	function automatic logic [7:0] exp_byte(input int a);
		int k;
		k = a & 32'h0000_ffff;
		return prog_q.exists(k) ? prog_q[k] : ERASED_BYTE;
	endfunction
	task automatic frame(input logic [7:0] op, input int na,
		input logic [23:0] a);
		host_u.start();
		host_u.xfer(op, 8, rx);
		for (int k = 2; k > 2 - na; k--) host_u.xfer(a[8*k +: 8], 8, rx);
	endtask
	task automatic cmd(input logic [7:0] op, input int na,
		input logic [23:0] a);
		frame(op, na, a);
		host_u.stop();
	endtask
	task automatic rd(input logic [23:0] a, input int n, input int skip);
		frame(OPC_FAST_READ, 3, a);
		host_u.xfer(8'($urandom), 8, rx);
		for (int i = 0; i < n; i++) begin
			host_u.xfer(8'($urandom), 8, rx);
			if (i >= skip) cmp_byte("read", exp_byte(int'(a) + i), rx);
		end
		host_u.stop();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge clk);
		cmp_flag("busy", 1'b0, busy);
	endtask
	initial begin
		void'($urandom(32'h9c20));
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		cmp_flag("standby", 1'b1, stby);
		cmp_flag("sleep", 1'b0, sleep);
		cmd(OPC_SECTOR_WIPE, 3, 24'h00_0000);
		cmp_flag("busy", 1'b0, busy);
		cmd(OPC_UNLOCK, 0, 24'h0);
		cmp_flag("latch", 1'b1, write_enable_latch);
		cmd(OPC_SECTOR_WIPE, 3, 24'h00_07a5);
		cmp_flag("busy", 1'b1, busy);
		cmp_flag("latch", 1'b0, write_enable_latch);
		frame(OPC_FAST_READ, 3, 24'h0);
		host_u.xfer(8'h00, 8, rx);
		host_u.xfer(8'h00, 8, rx);
		cmp_flag("oe_n", 1'b1, oe_n);
		host_u.stop();
		cmd(OPC_SLEEP, 0, 24'h0);
		cmp_flag("busy", 1'b1, busy);
		wait_idle();
		repeat (40) @(negedge clk);
		cmp_flag("sleep", 1'b0, sleep);
		cmp_flag("standby", 1'b1, stby);
		cmd(OPC_UNLOCK, 0, 24'h0);
		frame(OPC_PAGE_PROG, 3, 24'h00_00fe);
		for (int i = 0; i < 3; i++) begin
			d = 8'($urandom);
			prog_q[(254 + i) % 256] = d;
			host_u.xfer(d, 8, rx);
		end
		host_u.stop();
		cmp_flag("busy", 1'b1, busy);
		wait_idle();
		rd(24'h00_00fe, 2, 0);
		rd(24'h00_0000, 2, 0);
		rd(24'h00_ffff, 2, 1);
		cmd(OPC_UNLOCK, 0, 24'h0);
		frame(OPC_PAGE_PROG, 3, 24'h00_0010);
		host_u.xfer(8'h00, 8, rx);
		host_u.xfer(8'h00, 3, rx);
		host_u.stop();
		cmp_flag("busy", 1'b0, busy);
		frame(OPC_SECTOR_WIPE, 3, 24'h00_0000);
		host_u.xfer(8'h00, 8, rx);
		host_u.stop();
		cmp_flag("busy", 1'b0, busy);
		prot = 3'h1;
		frame(OPC_PAGE_PROG, 3, 24'h00_fff0);
		host_u.xfer(8'h00, 8, rx);
		host_u.stop();
		cmp_flag("busy", 1'b0, busy);
		for (int j = 0; j < 4; j++) begin
			cmd(ops[j], j < 2 ? 3 : 0, 24'h00_f000);
			cmp_flag("busy", 1'b0, busy);
		end
		cmp_flag("latch", 1'b1, write_enable_latch);
		prot = 3'h0;
		// chip erase with one byte too many must not run
		frame(OPC_CHIP_B, 1, 24'h0);
		host_u.stop();
		cmp_flag("busy", 1'b0, busy);
		cmd(OPC_SLEEP, 0, 24'h0);
		repeat (30) @(negedge clk);
		cmp_flag("sleep", 1'b1, sleep);
		cmp_flag("standby", 1'b0, stby);
		cmd(OPC_SECTOR_WIPE, 3, 24'h00_0000);
		cmp_flag("busy", 1'b0, busy);
		cmd(OPC_WAKE, 0, 24'h0);
		repeat (30) @(negedge clk);
		cmp_flag("sleep", 1'b0, sleep);
		cmd(8'h5a, 3, 24'($urandom));
		cmp_flag("busy", 1'b0, busy);
		cmp_flag("latch", 1'b1, write_enable_latch);
		results();
	end
	// the whole run needs about 17k cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		results();
	end
endmodule
bind serial_flash_cmds flash_props props_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.cs_n_i(cs_n_i), .sclk_i(sclk_i), .serial_in_i(serial_in_i),
	.protect_level_bits_i(protect_level_bits_i), .serial_out_o(serial_out_o),
	.serial_out_oe_n_o(serial_out_oe_n_o),
	.write_busy_flag_o(write_busy_flag_o),
	.write_enable_latch_o(write_enable_latch_o),
	.deep_sleep_o(deep_sleep_o), .standby_o(standby_o));
